// [vcc_top.sv]
// vcc_top.sv: digital control around an analog voltage comparator core.
// assumes a synchronous comparator output and a simple register port.
//
// Overview of operation
// - with unit_on set, begin task starts comparing; halt task stops it
// - ready event after core start-up; delay longer for internal refs
// - while running, every input crossing produces events until halted
// - rising event on upward output change, falling on downward
// - crossing event on every output change in either direction
// - capture task latches present output level into compare_outcome
// - mode register picks differential or single-ended and three speeds
// - positive_input_select routes a pin or divided supply positive
// - differential mode: negative input taken from pin_reference_select
// - single-ended: ladder reference from supply, pin or internal refs
// - analog_pin_reference source uses pin_reference_select for the pin
// - noise band in differential mode adds symmetric hysteresis
// - single-ended thresholds come from 64-level ladder level pair
// - above selects falling threshold; below selects rising threshold
// - single-ended mode ignores diff_noise_band_enable
// - event_task_links let events fire tasks with no software
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "vcc_map.svh"

module vcc_top
   import vcc_pkg::*;
#(
   parameter int INT_START_CYC = `VCC_INT_START_CYC,
   parameter int EXT_START_CYC = `VCC_EXT_START_CYC
) (
   input wire logic clk, // 100 MHz system clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [11:0] reg_addr, // byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic core_out, // comparator output, 1 = above
   output logic core_power, // core powered and comparing
   output logic [2:0] core_pos_sel, // positive_input mux select
   output logic [2:0] core_neg_pin_sel, // pin_reference_select to mux
   output logic [2:0] core_ladder_src, // ladder reference source
   output logic core_single_ended, // 1 = single-ended mode
   output logic [1:0] core_speed, // speed setting
   output logic core_band_on, // differential noise band enable
   output logic [5:0] core_ladder_level, // present ladder tap
   output logic irq // interrupt request
);

   initial begin
      if (INT_START_CYC < 1 || EXT_START_CYC < 1 ||
          INT_START_CYC > 65535 || EXT_START_CYC > 65535)
         $error("vcc_top: start-up counts must be 1..65535");
   end

   //--------------------------------------------------------------------
   // state
   //--------------------------------------------------------------------
   typedef struct packed {
      vcc_run_t run;
      logic [15:0] wait_cnt;
      logic prev_out;
      logic ev_ready;
      logic ev_fall;
      logic ev_rise;
      logic ev_cross;
      logic [4:0] links;
      logic [3:0] mask;
      logic outcome;
      logic unit_on;
      logic [2:0] pos_sel;
      logic [2:0] ladder_src;
      logic [2:0] pin_ref;
      logic [5:0] upper_lvl;
      logic [5:0] lower_lvl;
      logic [1:0] speed;
      logic single_ended;
      logic band_on;
      logic [31:0] rdata;
      logic irq;
      logic [5:0] ladder_tap;
      logic band;
   } vcc_state_t;

   vcc_state_t cur_ff;
   vcc_state_t nxt_ff;

   // write decode helpers
   logic wr_begin;
   logic wr_halt;
   logic wr_capture;
   logic do_begin;
   logic do_halt;
   logic do_capture;
   logic running;
   logic up_edge;
   logic down_edge;
   logic ready_pulse;
   logic uses_int_ref;

   //--------------------------------------------------------------------
   // task and event pulses
   //--------------------------------------------------------------------
   // only a one in bit 0 triggers a task; the other bits are ignored
   assign wr_begin = reg_wr && reg_addr == `VCC_OFS_TASK_BEGIN &&
                     reg_wdata[0];
   assign wr_halt = reg_wr && reg_addr == `VCC_OFS_TASK_HALT &&
                    reg_wdata[0];
   assign wr_capture = reg_wr && reg_addr == `VCC_OFS_TASK_CAPTURE &&
                       reg_wdata[0];
   assign running = cur_ff.run == VCC_RUN;
   // edges only counted while running, so stray output moves in idle
   // or warm-up never show as events
   assign up_edge = running && core_out && !cur_ff.prev_out;
   assign down_edge = running && !core_out && cur_ff.prev_out;
   assign ready_pulse = cur_ff.run == VCC_WARM && cur_ff.wait_cnt == 16'h0;
   // internal refs need only be waited for in single-ended mode
   assign uses_int_ref = cur_ff.single_ended &&
                         cur_ff.ladder_src <= `VCC_SRC_INT_MAX;
   // links turn local events into tasks in the same cycle
   assign do_begin = wr_begin;
   assign do_halt = wr_halt ||
      (ready_pulse && cur_ff.links[`VCC_LNK_READY_HALT]) ||
      (down_edge && cur_ff.links[`VCC_LNK_FALL_HALT]) ||
      (up_edge && cur_ff.links[`VCC_LNK_RISE_HALT]) ||
      ((up_edge || down_edge) &&
       cur_ff.links[`VCC_LNK_CROSS_HALT]);
   assign do_capture = wr_capture ||
      (ready_pulse && cur_ff.links[`VCC_LNK_READY_CAPTURE]);

   //--------------------------------------------------------------------
   // next state
   //--------------------------------------------------------------------
   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.prev_out = core_out;
      // run sequencer: begin only acts while the unit is switched on
      case (cur_ff.run)
         VCC_IDLE: begin
            if (do_begin && cur_ff.unit_on) begin
               nxt_ff.run = VCC_WARM;
               nxt_ff.wait_cnt = uses_int_ref ?
                  16'(INT_START_CYC - 1) : 16'(EXT_START_CYC - 1);
            end
         end
         VCC_WARM: begin
            if (ready_pulse) begin
               nxt_ff.run = VCC_RUN;
            end else begin
               nxt_ff.wait_cnt = cur_ff.wait_cnt - 16'h1;
            end
         end
         VCC_RUN: begin
            nxt_ff.run = VCC_RUN;
         end
         default: begin
            nxt_ff.run = VCC_IDLE;
         end
      endcase
      // halt or switching the unit off wins over everything else
      if (do_halt || !cur_ff.unit_on) begin
         nxt_ff.run = VCC_IDLE;
      end
      // capture present level of the core output
      if (do_capture) begin
         nxt_ff.outcome = core_out;
      end

      // register writes; event writes of zero clear, a one is ignored
      if (reg_wr) begin
         case (reg_addr)
            `VCC_OFS_EV_READY: if (!reg_wdata[0]) nxt_ff.ev_ready = 1'b0;
            `VCC_OFS_EV_FALLING: if (!reg_wdata[0]) nxt_ff.ev_fall = 1'b0;
            `VCC_OFS_EV_RISING: if (!reg_wdata[0]) nxt_ff.ev_rise = 1'b0;
            `VCC_OFS_EV_CROSS: if (!reg_wdata[0]) nxt_ff.ev_cross = 1'b0;
            `VCC_OFS_LINKS: nxt_ff.links = reg_wdata[4:0];
            `VCC_OFS_IRQ_MASK: nxt_ff.mask = reg_wdata[3:0];
            `VCC_OFS_IRQ_SET: nxt_ff.mask = cur_ff.mask | reg_wdata[3:0];
            `VCC_OFS_IRQ_CLR: nxt_ff.mask = cur_ff.mask & ~reg_wdata[3:0];
            `VCC_OFS_UNIT_ON: nxt_ff.unit_on = reg_wdata[0];
            `VCC_OFS_POS_SEL: nxt_ff.pos_sel = reg_wdata[2:0];
            `VCC_OFS_LADDER_SRC: nxt_ff.ladder_src = reg_wdata[2:0];
            `VCC_OFS_PIN_REF: nxt_ff.pin_ref = reg_wdata[2:0];
            `VCC_OFS_LEVEL_PAIR: begin
               nxt_ff.lower_lvl = reg_wdata[`VCC_LOWER_LSB +: `VCC_LEVEL_W];
               nxt_ff.upper_lvl = reg_wdata[`VCC_UPPER_LSB +: `VCC_LEVEL_W];
            end
            `VCC_OFS_MODE: begin
               nxt_ff.speed = reg_wdata[`VCC_MODE_SPEED_LSB +: 2];
               nxt_ff.single_ended = reg_wdata[`VCC_MODE_MAIN_BIT];
            end
            `VCC_OFS_NOISE_BAND: nxt_ff.band_on = reg_wdata[0];
            default: begin
               nxt_ff.links = cur_ff.links;
            end
         endcase
      end

      // events set after the clear so a coincident event is kept
      if (ready_pulse) nxt_ff.ev_ready = 1'b1;
      if (up_edge) nxt_ff.ev_rise = 1'b1;
      if (down_edge) nxt_ff.ev_fall = 1'b1;
      if (up_edge || down_edge) nxt_ff.ev_cross = 1'b1;

      // interrupt from sticky flags and mask, registered with the flags
      nxt_ff.irq = |({nxt_ff.ev_cross, nxt_ff.ev_rise, nxt_ff.ev_fall,
                      nxt_ff.ev_ready} & nxt_ff.mask);

      // read data, registered so it stands in the cycle after the strobe
      nxt_ff.rdata = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            `VCC_OFS_EV_READY: nxt_ff.rdata = {31'h0, cur_ff.ev_ready};
            `VCC_OFS_EV_FALLING: nxt_ff.rdata = {31'h0, cur_ff.ev_fall};
            `VCC_OFS_EV_RISING: nxt_ff.rdata = {31'h0, cur_ff.ev_rise};
            `VCC_OFS_EV_CROSS: nxt_ff.rdata = {31'h0, cur_ff.ev_cross};
            `VCC_OFS_LINKS: nxt_ff.rdata = {27'h0, cur_ff.links};
            `VCC_OFS_IRQ_MASK,
            `VCC_OFS_IRQ_SET,
            `VCC_OFS_IRQ_CLR: nxt_ff.rdata = {28'h0, cur_ff.mask};
            `VCC_OFS_OUTCOME: nxt_ff.rdata = {31'h0, cur_ff.outcome};
            `VCC_OFS_UNIT_ON: nxt_ff.rdata = {31'h0, cur_ff.unit_on};
            `VCC_OFS_POS_SEL: nxt_ff.rdata = {29'h0, cur_ff.pos_sel};
            `VCC_OFS_LADDER_SRC: nxt_ff.rdata = {29'h0, cur_ff.ladder_src};
            `VCC_OFS_PIN_REF: nxt_ff.rdata = {29'h0, cur_ff.pin_ref};
            `VCC_OFS_LEVEL_PAIR: nxt_ff.rdata = {18'h0,
               cur_ff.upper_lvl, 2'h0, cur_ff.lower_lvl};
            `VCC_OFS_MODE: nxt_ff.rdata = {23'h0, cur_ff.single_ended,
               6'h0, cur_ff.speed};
            `VCC_OFS_NOISE_BAND: nxt_ff.rdata = {31'h0, cur_ff.band_on};
            default: nxt_ff.rdata = 32'h0; // tasks and unmapped read 0
         endcase
      end

      // negative side: pin in differential, or ladder in single-ended;
      // above uses falling level, below the rising level
      nxt_ff.ladder_tap = nxt_ff.prev_out ? nxt_ff.lower_lvl :
                          nxt_ff.upper_lvl;
      // band is forced off in single-ended so the register has no effect
      nxt_ff.band = nxt_ff.band_on && !nxt_ff.single_ended;
   end

   //--------------------------------------------------------------------
   // register the state
   //--------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur_ff <= '0;
         cur_ff.run <= VCC_IDLE;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   //--------------------------------------------------------------------
   // core-facing outputs straight from flip-flops, except core_power, decoded from the run state
   //--------------------------------------------------------------------
   // the analog mux uses core_ladder_src only when single-ended
   assign reg_rdata = cur_ff.rdata;
   assign core_power = cur_ff.run != VCC_IDLE;
   assign core_pos_sel = cur_ff.pos_sel;
   assign core_neg_pin_sel = cur_ff.pin_ref;
   assign core_ladder_src = cur_ff.ladder_src;
   assign core_single_ended = cur_ff.single_ended;
   assign core_speed = cur_ff.speed;
   assign core_band_on = cur_ff.band;
   assign core_ladder_level = cur_ff.ladder_tap;
   assign irq = cur_ff.irq;

endmodule : vcc_top

// [vcc_map.svh]
// vcc_map.svh: register offsets, field positions and
// timing counts for the voltage comparator control block.
// assumes a 12-bit byte address from the register port.
`ifndef VCC_MAP_SVH
`define VCC_MAP_SVH

`define VCC_OFS_TASK_BEGIN 12'h000
`define VCC_OFS_TASK_HALT 12'h004
`define VCC_OFS_TASK_CAPTURE 12'h008
`define VCC_OFS_EV_READY 12'h100
`define VCC_OFS_EV_FALLING 12'h104
`define VCC_OFS_EV_RISING 12'h108
`define VCC_OFS_EV_CROSS 12'h10c
`define VCC_OFS_LINKS 12'h200
`define VCC_OFS_IRQ_MASK 12'h300
`define VCC_OFS_IRQ_SET 12'h304
`define VCC_OFS_IRQ_CLR 12'h308
`define VCC_OFS_OUTCOME 12'h400
`define VCC_OFS_UNIT_ON 12'h500
`define VCC_OFS_POS_SEL 12'h504
`define VCC_OFS_LADDER_SRC 12'h508
`define VCC_OFS_PIN_REF 12'h50c
`define VCC_OFS_LEVEL_PAIR 12'h530
`define VCC_OFS_MODE 12'h534
`define VCC_OFS_NOISE_BAND 12'h538

// event_task_links bit positions
`define VCC_LNK_READY_CAPTURE 0
`define VCC_LNK_READY_HALT 1
`define VCC_LNK_FALL_HALT 2
`define VCC_LNK_RISE_HALT 3
`define VCC_LNK_CROSS_HALT 4

// irq bit positions: ready, falling, rising, crossing
`define VCC_IRQ_READY 0
`define VCC_IRQ_FALL 1
`define VCC_IRQ_RISE 2
`define VCC_IRQ_CROSS 3

// field widths and positions
`define VCC_LEVEL_W 6
`define VCC_LOWER_LSB 0
`define VCC_UPPER_LSB 8
`define VCC_MODE_SPEED_LSB 0
`define VCC_MODE_MAIN_BIT 8

// ladder source codes: internal references (1.2/1.8/2.4 V) up to VCC_SRC_INT_MAX, then supply and pin
`define VCC_SRC_INT_MAX 3'h2
`define VCC_SRC_SUPPLY 3'h4
`define VCC_SRC_PIN 3'h5

// start-up times in ns; cycles derived at 100 MHz (10 ns)
`define VCC_CLK_NS 10
`define VCC_INT_REF_START_NS 500
`define VCC_EXT_REF_START_NS 200
`define VCC_INT_START_CYC \
   ((`VCC_INT_REF_START_NS + `VCC_CLK_NS - 1) / `VCC_CLK_NS)
`define VCC_EXT_START_CYC \
   ((`VCC_EXT_REF_START_NS + `VCC_CLK_NS - 1) / `VCC_CLK_NS)

`endif

// [vcc_pkg.sv]
// vcc_pkg.sv: types shared by the voltage comparator control block.
// assumes vcc_map.svh supplies all numeric constants.
package vcc_pkg;

   // run state of the comparator core, one-hot
   typedef enum logic [2:0] {
      VCC_IDLE = 3'b001,
      VCC_WARM = 3'b010,
      VCC_RUN = 3'b100
   } vcc_run_t;

   // speed settings written into mode_config
   typedef enum logic [1:0] {
      VCC_SPD_LOW = 2'h0,
      VCC_SPD_NORMAL = 2'h1,
      VCC_SPD_HIGH = 2'h2
   } vcc_speed_t;

endpackage : vcc_pkg

// [vcc_chk.sv]
// vcc_chk.sv: concurrent checks on the comparator control ports.
// assumes it is bound to vcc_top and sees only its ports.
`timescale 1ns/1ps
module vcc_chk #(
   parameter int INT_START_CYC = 50,
   parameter int EXT_START_CYC = 20
) (
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic [11:0] reg_addr, // address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [31:0] reg_rdata, // read data
   input wire logic core_out, // core output
   input wire logic core_power, // core on
   input wire logic [2:0] core_pos_sel, // positive mux
   input wire logic [2:0] core_neg_pin_sel, // pin ref mux
   input wire logic core_single_ended, // mode
   input wire logic [1:0] core_speed, // speed
   input wire logic core_band_on, // band enable
   input wire logic [5:0] core_ladder_level // ladder tap
);
   logic [31:0] mode_ff, pos_ff, pin_ff, pair_ff;
   logic on_ff;
   // shadows of config writes, so outputs can be tied to written values
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_ff <= 32'h0;
         pos_ff <= 32'h0;
         pin_ff <= 32'h0;
         pair_ff <= 32'h0;
         on_ff <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 12'h534) mode_ff <= reg_wdata;
         if (reg_addr == 12'h504) pos_ff <= reg_wdata;
         if (reg_addr == 12'h50c) pin_ff <= reg_wdata;
         if (reg_addr == 12'h530) pair_ff <= reg_wdata;
         if (reg_addr == 12'h500) on_ff <= reg_wdata[0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_BEGIN_RUNS: assert property (
      reg_wr && reg_addr == 12'h000 && reg_wdata[0] && on_ff |=> core_power)
      else $error("begin task did not power the core");
   AST_HALT_STOPS: assert property (
      reg_wr && reg_addr == 12'h004 && reg_wdata[0] |=> !core_power)
      else $error("halt task left the core powered");
   AST_BEGIN_NEEDS_ONE: assert property (
      reg_wr && reg_addr == 12'h000 && !reg_wdata[0] && !core_power
      |=> !core_power) else $error("begin ran without bit zero");
   AST_BAND_GATED: assert property (
      core_single_ended |-> !core_band_on)
      else $error("noise band on in single-ended mode");
   AST_LEVEL_TRACKS: assert property (
      pair_ff == $past(pair_ff) |-> core_ladder_level ==
      ($past(core_out) ? pair_ff[5:0] : pair_ff[13:8]))
      else $error("ladder tap does not follow output");
   AST_MODE_COPY: assert property (
      reg_wr && reg_addr == 12'h534 |-> ##2 core_speed == mode_ff[1:0]
      && core_single_ended == mode_ff[8]) else $error("mode not applied");
   AST_POS_COPY: assert property (
      reg_wr && reg_addr == 12'h504 |-> ##2 core_pos_sel == pos_ff[2:0])
      else $error("positive select not applied");
   AST_PIN_COPY: assert property (
      reg_wr && reg_addr == 12'h50c |-> ##2 core_neg_pin_sel == pin_ff[2:0])
      else $error("pin reference not applied");
   AST_OUTCOME_BIT: assert property (
      $past(reg_rd) && $past(reg_addr) == 12'h400 |-> reg_rdata[31:1] == 0)
      else $error("outcome has stray bits");
endmodule : vcc_chk

bind vcc_top vcc_chk #(
   .INT_START_CYC(INT_START_CYC),
   .EXT_START_CYC(EXT_START_CYC)
) u_chk (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .core_out(core_out), .core_power(core_power),
   .core_pos_sel(core_pos_sel), .core_neg_pin_sel(core_neg_pin_sel),
   .core_single_ended(core_single_ended), .core_speed(core_speed),
   .core_band_on(core_band_on), .core_ladder_level(core_ladder_level)
);

// [vcc_core_model.sv]
// vcc_core_model.sv: behavioural stand-in for the analog comparator core.
// assumes the bench gives the positive input on the 64-level ladder scale.
`timescale 1ns/1ps
module vcc_core_model (
   input wire logic clk, // system clock
   input wire logic core_power, // core powered
   input wire logic core_single_ended, // single-ended mode
   input wire logic [5:0] core_ladder_level, // present ladder tap
   input wire logic [5:0] vin_level, // positive input level
   output logic core_out // 1 = above
);
   // unpowered core reads below; differential compares with mid-scale pin
   always_ff @(posedge clk) begin
      if (!core_power)
         core_out <= 1'b0;
      else if (core_single_ended)
         core_out <= vin_level > core_ladder_level;
      else
         core_out <= vin_level > 6'h20;
   end
endmodule : vcc_core_model

// [tb_top.sv]
// tb_top.sv: self-checking bench for the comparator control block.
// assumes vcc_top, vcc_core_model and the bound checker are compiled.
`timescale 1ns/1ps
module tb_top;
   localparam int INT_CYC = 8;
   localparam int EXT_CYC = 2;
   localparam int WATCH = 5000; // whole run needs well under 1000 cycles
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic core_out, core_power, core_single_ended, core_band_on, irq;
   logic [2:0] core_pos_sel, core_neg_pin_sel, core_ladder_src;
   logic [1:0] core_speed;
   logic [5:0] core_ladder_level;
   logic [5:0] vin_level = 6'h0;
   int fail_count = 0;
   int checks_done = 0;
   int seed = 7;
   int exp_ev[4] = '{0, 0, 0, 0}; // ready, falling, rising, crossing
   vcc_top #(.INT_START_CYC(INT_CYC), .EXT_START_CYC(EXT_CYC)) dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_out(core_out), .core_power(core_power),
      .core_pos_sel(core_pos_sel), .core_neg_pin_sel(core_neg_pin_sel),
      .core_ladder_src(core_ladder_src), .core_speed(core_speed),
      .core_single_ended(core_single_ended), .core_band_on(core_band_on),
      .core_ladder_level(core_ladder_level), .irq(irq));
   vcc_core_model u_core (.clk(clk), .core_power(core_power),
      .core_single_ended(core_single_ended), .vin_level(vin_level),
      .core_ladder_level(core_ladder_level), .core_out(core_out));
   // 100 MHz clock
   always #5 clk = ~clk;
   task automatic give_verdict();
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask : chk
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(string what, logic [11:0] a, logic [31:0] want);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(what, reg_rdata, want);
   endtask : rd_chk
   task automatic nap(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : nap
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (WATCH) @(posedge clk);
      fail_count++;
      give_verdict();
   end
   initial begin
      int v;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      foreach (exp_ev[i])
         rd_chk("flag", 12'h100 + 12'(4 * i), exp_ev[i]);
      rd_chk("outcome", 12'h400, 0);
      rd_chk("begin reg", 12'h000, 0);
      rd_chk("unmapped", 12'h600, 0);
      // every select is set while the unit is off
      repeat (3) begin
         v = $random(seed) & 7;
         wr(12'h504, v);
         wr(12'h50c, 7 - v);
         nap(2);
         chk("pos sel", 32'(core_pos_sel), v);
         chk("pin ref", 32'(core_neg_pin_sel), 7 - v);
      end
      for (v = 0; v < 3; v++) begin
         wr(12'h534, v);
         nap(2);
         chk("speed", 32'(core_speed), v);
      end
      wr(12'h538, 1);
      nap(2);
      chk("band diff", 32'(core_band_on), 1);
      wr(12'h534, 32'h100);
      nap(2);
      chk("band single", 32'(core_band_on), 0);
      chk("single", 32'(core_single_ended), 1);
      wr(12'h530, 32'h280a); // rising tap 40, falling tap 10
      wr(12'h500, 1);
      wr(12'h000, 2);
      nap(2);
      chk("no start", 32'(core_power), 0);
      // internal reference warms longer than the supply reference
      for (v = 0; v < 5; v += 4) begin
         wr(12'h500, 0);
         wr(12'h508, v);
         nap(0);
         chk("ladder src", 32'(core_ladder_src), v);
         wr(12'h500, 1);
         wr(12'h000, 1);
         nap(0);
         chk("power", 32'(core_power), 1);
         nap(2);
         rd_chk("early ready", 12'h100, v / 4);
         nap(8);
         rd_chk("ready", 12'h100, 1);
         wr(12'h100, 0);
      end
      nap(1);
      chk("rising tap", 32'(core_ladder_level), 40);
      vin_level <= 6'd50;
      nap(4);
      chk("falling tap", 32'(core_ladder_level), 10);
      vin_level <= 6'd20; // inside the band: no change expected
      nap(4);
      rd_chk("no fall", 12'h104, 0);
      vin_level <= 6'd5;
      nap(4);
      exp_ev = '{0, 1, 1, 1};
      foreach (exp_ev[i])
         rd_chk("event", 12'h100 + 12'(4 * i), exp_ev[i]);
      wr(12'h304, 32'h4);
      nap(2);
      chk("irq set", 32'(irq), 1);
      wr(12'h308, 32'h4);
      nap(2);
      chk("irq clr", 32'(irq), 0);
      wr(12'h300, 32'h8);
      nap(2);
      chk("irq cross", 32'(irq), 1);
      wr(12'h10c, 0);
      nap(2);
      chk("irq cleared", 32'(irq), 0);
      rd_chk("mask", 12'h300, 8);
      for (v = 1; v >= 0; v--) begin
         vin_level <= v ? 6'd50 : 6'd5;
         nap(4);
         wr(12'h008, 1);
         rd_chk("outcome", 12'h400, v);
      end
      wr(12'h004, 1);
      nap(1);
      chk("halted", 32'(core_power), 0);
      for (v = 1; v < 4; v++) wr(12'h100 + 12'(4 * v), 0);
      vin_level <= 6'd50;
      nap(4);
      rd_chk("idle rise", 12'h108, 0);
      wr(12'h200, 32'h3); // ready fires capture and halt
      wr(12'h000, 1);
      nap(14);
      chk("linked halt", 32'(core_power), 0);
      rd_chk("linked capture", 12'h400, 1);
      give_verdict();
   end
endmodule : tb_top
